// file: hdl/xsm_enable_mask.sv
// Extended-state enable mask register with its access checks and state-operation gating.
//
// Notes on behaviour
// - Reset leaves the enable mask holding only bit 0 set.
// - Write faults if bits 63 or 61:3 nonzero, bit 0 clear, or bits 2:1 equal 10.
// - Bits 63 and 61:3 are reserved and must stay zero.
// - Bit 62 enables the profiling extension and its state handling.
// - Bit 2 enables wide vector state; needed for the wide vector extension.
// - Bit 1 enables vector state; required with bit 2 and for wide vectors.
// - Bit 0 selects scalar floating-point state and always reads one.
// - The mask is extended control register 0, read and written by operations.
// - Reads allowed at any ring; writes only at ring 0.
// - Save and restore act on operand mask ANDed with the enable mask.
// - Wide vector instruction without OS enablement raises undefined-opcode fault.
// - Control register four bit 18 gates the read and write operations.
// - Save-area offsets are fixed and never compacted around absent components.
// - Upper vector bits survive mode changes; restore may update them anywhere.
// - Supported mask reports bits 0, 1, 2 and 62 for the four components.
// - Query subfunction 0 first result gives save size for enabled components.
// - Query subfunction 1 reports optimized save support in a result bit.
// - The 64-byte header with the saved-component vector sits at byte 512.
// - Restore initialises selected components whose saved bit is clear.
`timescale 1ns/1ns
`default_nettype none

module xsm_enable_mask (
  input wire logic clk,                                // 100 MHz core clock.
  input wire logic rst,                                // Synchronous reset, active high.
  input wire logic [31:0] control_register_four,       // Current control register four.
  input wire logic [1:0] priv_ring,                    // Current privilege ring.
  input wire logic xreg_rd_req,                        // Control register read operation pulse.
  input wire logic xreg_wr_req,                        // Control register write operation pulse.
  input wire logic [31:0] xreg_index,                  // Extended control register index.
  input wire logic [63:0] xreg_wr_data,                // Value to write.
  output logic [63:0] xreg_rd_data,                    // Value read, registered.
  output logic xreg_done,                              // Access completed without fault.
  output logic protection_fault,                       // Protection fault pulse.
  output logic undefined_opcode_fault,                 // Undefined-opcode fault pulse.
  output logic [63:0] feature_state_enable_mask,       // Current enable mask.
  output logic profiling_state_enable,                 // Profiling extension enabled.
  output logic wide_vector_usable,                     // Wide vector extension usable.
  input wire logic wide_vec_exec,                      // Wide vector instruction issued.
  input wire logic state_op_req,                       // Save or restore operation pulse.
  input wire logic [1:0] state_op_kind,                // Operation kind, xsm_op_t coding.
  input wire logic [63:0] operand_mask_pair,           // Instruction mask operand.
  input wire logic [63:0] saved_component_vector,      // Header vector read from the image.
  output logic state_op_done,                          // Operation answer pulse.
  output logic [63:0] op_select_mask,                  // Components the operation handles.
  output logic [63:0] op_load_mask,                    // Restore: load from memory.
  output logic [63:0] op_init_mask,                    // Restore: set initial values.
  output logic [63:0] op_saved_vector_set,             // Save: header bits to set.
  output logic upper_vector_write_en,                  // Upper vector bits may be written.
  input wire logic [11:0] image_byte_offset,           // Save-image byte being restored.
  output logic image_byte_ignored,                     // That byte is skipped by restore.
  input wire logic query_req,                          // Feature query pulse.
  input wire logic [31:0] query_subfn,                 // Feature query subfunction.
  output logic query_done,                             // Query answer pulse.
  output logic [31:0] query_result_a,                  // First result register.
  output logic [31:0] query_result_b,                  // Second result register.
  output logic [31:0] query_result_c,                  // Third result register.
  output logic [31:0] query_result_d                   // Fourth result register.
);

  // ----------------------------------------------------------------
  // Decoding used by the write check and the feature query
  // ----------------------------------------------------------------

  // True when a candidate mask breaks the encoding constraints.
  function automatic logic mask_invalid(input logic [63:0] m);
    logic bad;
    bad = 1'b0;
    if ((m & xsm_pkg::MASK_RSVD) != 64'h0000_0000_0000_0000) begin
      bad = 1'b1;
    end
    if (!m[xsm_pkg::BIT_SCALAR_FP]) begin
      bad = 1'b1;
    end
    if (m[xsm_pkg::BIT_WIDE_VECTOR:xsm_pkg::BIT_VECTOR] == xsm_pkg::BAD_VEC_PAIR) begin
      bad = 1'b1;
    end
    if ((m & ~xsm_pkg::SUPPORTED_MASK) != 64'h0000_0000_0000_0000) begin
      bad = 1'b1;
    end
    return bad;
  endfunction : mask_invalid

  // Byte size of the save area for a given set of enabled components.
  function automatic logic [31:0] area_size(input logic [63:0] m);
    logic [31:0] sz;
    sz = xsm_pkg::HEADER_OFS + xsm_pkg::HEADER_SIZE;
    // Offsets are fixed, so a gap stays where a component is absent.
    if (m[xsm_pkg::BIT_WIDE_VECTOR]) begin
      sz = xsm_pkg::WIDE_VEC_OFS + xsm_pkg::WIDE_VEC_SIZE;
    end
    if (m[xsm_pkg::BIT_PROFILING]) begin
      sz = xsm_pkg::PROFILING_OFS + xsm_pkg::PROFILING_SIZE;
    end
    return sz;
  endfunction : area_size

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [63:0] mask_q, mask_d;
  logic [63:0] rd_data_q, rd_data_d;
  logic done_q, done_d;
  logic pf_q, pf_d;
  logic uf_q, uf_d;
  logic op_done_q, op_done_d;
  logic [63:0] sel_q, sel_d;
  logic [63:0] load_q, load_d;
  logic [63:0] init_q, init_d;
  logic [63:0] setv_q, setv_d;
  logic upper_q, upper_d;
  logic ign_q, ign_d;
  logic qdone_q, qdone_d;
  logic [31:0] qa_q, qa_d;
  logic [31:0] qb_q, qb_d;
  logic [31:0] qc_q, qc_d;
  logic [31:0] qd_q, qd_d;
  logic os_en;
  logic idx_ok;
  logic [63:0] op_sel;

  assign os_en = control_register_four[xsm_pkg::OS_MGMT_ENABLE_BIT];
  assign idx_ok = (xreg_index == xsm_pkg::XREG_IDX_MASK);
  assign op_sel = operand_mask_pair & mask_q;

  // ----------------------------------------------------------------
  // Control register access and wide vector fault
  // ----------------------------------------------------------------

  // Access requests are answered one cycle later; a read and a write
  // in the same cycle are treated as the write only.
  always_comb begin
    mask_d = mask_q;
    rd_data_d = rd_data_q;
    done_d = 1'b0;
    pf_d = 1'b0;
    uf_d = 1'b0;
    if (xreg_wr_req) begin
      if (!os_en) begin
        uf_d = 1'b1;
      end else if (priv_ring != xsm_pkg::RING_KERNEL || !idx_ok) begin
        pf_d = 1'b1;
      end else if (mask_invalid(xreg_wr_data)) begin
        pf_d = 1'b1;
      end else begin
        mask_d = xreg_wr_data;
        done_d = 1'b1;
      end
      // On a fault mask_d keeps its held value.
    end else if (xreg_rd_req) begin
      if (!os_en) begin
        uf_d = 1'b1;
      end else if (!idx_ok) begin
        pf_d = 1'b1;
      end else begin
        // Any ring may read.
        rd_data_d = mask_q | xsm_pkg::MASK_RESET;
        done_d = 1'b1;
      end
    end
    // The wide vector unit needs the OS enable plus both vector bits.
    if (wide_vec_exec && !(os_en &&
        mask_q[xsm_pkg::BIT_WIDE_VECTOR:xsm_pkg::BIT_VECTOR] == xsm_pkg::WIDE_VEC_PAIR)) begin
      uf_d = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mask_q <= xsm_pkg::MASK_RESET;
      rd_data_q <= 64'h0000_0000_0000_0000;
      done_q <= 1'b0;
      pf_q <= 1'b0;
      uf_q <= 1'b0;
    end else begin
      mask_q <= mask_d;
      rd_data_q <= rd_data_d;
      done_q <= done_d;
      pf_q <= pf_d;
      uf_q <= uf_d;
    end
  end

  // ----------------------------------------------------------------
  // Save and restore component selection
  // ----------------------------------------------------------------

  // Masks hold their last value between operations so the data path can
  // sample them at leisure after the done pulse.
  always_comb begin
    op_done_d = 1'b0;
    sel_d = sel_q;
    load_d = load_q;
    init_d = init_q;
    setv_d = setv_q;
    upper_d = 1'b0;
    if (state_op_req && state_op_kind != xsm_pkg::XSM_OP_NONE) begin
      op_done_d = 1'b1;
      sel_d = op_sel;
      if (state_op_kind == xsm_pkg::XSM_OP_RESTORE) begin
        load_d = op_sel & saved_component_vector;
        init_d = op_sel & ~saved_component_vector;
        setv_d = 64'h0000_0000_0000_0000;
        // Only restore touches the upper vector half, in any mode;
        // mode transitions never raise this enable.
        upper_d = op_sel[xsm_pkg::BIT_WIDE_VECTOR];
      end else begin
        load_d = 64'h0000_0000_0000_0000;
        init_d = 64'h0000_0000_0000_0000;
        setv_d = op_sel;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      op_done_q <= 1'b0;
      sel_q <= 64'h0000_0000_0000_0000;
      load_q <= 64'h0000_0000_0000_0000;
      init_q <= 64'h0000_0000_0000_0000;
      setv_q <= 64'h0000_0000_0000_0000;
      upper_q <= 1'b0;
    end else begin
      op_done_q <= op_done_d;
      sel_q <= sel_d;
      load_q <= load_d;
      init_q <= init_d;
      setv_q <= setv_d;
      upper_q <= upper_d;
    end
  end

  // ----------------------------------------------------------------
  // Software area check and feature query
  // ----------------------------------------------------------------

  // The software area lies inside the legacy region, so restore simply
  // skips it rather than loading reserved content into live state.
  always_comb begin
    ign_d = (image_byte_offset >= xsm_pkg::SW_AREA_FIRST) &&
            (image_byte_offset <= xsm_pkg::SW_AREA_LAST);
    qdone_d = query_req;
    qa_d = qa_q;
    qb_d = qb_q;
    qc_d = qc_q;
    qd_d = qd_q;
    if (query_req) begin
      qa_d = 32'h0000_0000;
      qb_d = 32'h0000_0000;
      qc_d = 32'h0000_0000;
      qd_d = 32'h0000_0000;
      if (query_subfn == xsm_pkg::SUBFN_SIZES) begin
        qa_d = area_size(mask_q);
        qb_d = area_size(xsm_pkg::SUPPORTED_MASK);
        qc_d = xsm_pkg::SUPPORTED_MASK[31:0];
        qd_d = xsm_pkg::SUPPORTED_MASK[63:32];
      end else if (query_subfn == xsm_pkg::SUBFN_FEATURES) begin
        qa_d[xsm_pkg::OPT_SAVE_RESULT_BIT] = xsm_pkg::OPT_SAVE_SUPPORTED;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ign_q <= 1'b0;
      qdone_q <= 1'b0;
      qa_q <= 32'h0000_0000;
      qb_q <= 32'h0000_0000;
      qc_q <= 32'h0000_0000;
      qd_q <= 32'h0000_0000;
    end else begin
      ign_q <= ign_d;
      qdone_q <= qdone_d;
      qa_q <= qa_d;
      qb_q <= qb_d;
      qc_q <= qc_d;
      qd_q <= qd_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign xreg_rd_data = rd_data_q;
  assign xreg_done = done_q;
  assign protection_fault = pf_q;
  assign undefined_opcode_fault = uf_q;
  assign feature_state_enable_mask = mask_q;
  assign profiling_state_enable = mask_q[xsm_pkg::BIT_PROFILING];
  assign wide_vector_usable = os_en &&
    (mask_q[xsm_pkg::BIT_WIDE_VECTOR:xsm_pkg::BIT_VECTOR] == xsm_pkg::WIDE_VEC_PAIR);
  assign state_op_done = op_done_q;
  assign op_select_mask = sel_q;
  assign op_load_mask = load_q;
  assign op_init_mask = init_q;
  assign op_saved_vector_set = setv_q;
  assign upper_vector_write_en = upper_q;
  assign image_byte_ignored = ign_q;
  assign query_done = qdone_q;
  assign query_result_a = qa_q;
  assign query_result_b = qb_q;
  assign query_result_c = qc_q;
  assign query_result_d = qd_q;

endmodule : xsm_enable_mask

`default_nettype wire

// file: hdl/xsm_pkg.sv
// Package of constants for the extended-state enable mask block.
package xsm_pkg;

  // ----------------------------------------------------------------
  // Enable mask layout and reset value
  // ----------------------------------------------------------------
  localparam int MASK_W = 64;
  localparam int BIT_SCALAR_FP = 0;
  localparam int BIT_VECTOR = 1;
  localparam int BIT_WIDE_VECTOR = 2;
  localparam int BIT_PROFILING = 62;
  localparam int BIT_EXPANSION = 63;
  localparam int RSVD_LO = 3;
  localparam int RSVD_HI = 63;
  localparam logic [63:0] MASK_RESET = 64'h0000_0000_0000_0001;
  localparam logic [63:0] MASK_RSVD = 64'hBFFF_FFFF_FFFF_FFF8;
  localparam logic [1:0] BAD_VEC_PAIR = 2'h2;
  localparam logic [1:0] WIDE_VEC_PAIR = 2'h3;

  // ----------------------------------------------------------------
  // Extended control register space and privilege
  // ----------------------------------------------------------------
  localparam logic [31:0] XREG_IDX_MASK = 32'h0000_0000;
  localparam logic [1:0] RING_KERNEL = 2'h0;
  localparam int OS_MGMT_ENABLE_BIT = 18;

  // ----------------------------------------------------------------
  // Component support reported by the feature query
  // ----------------------------------------------------------------
  localparam logic [63:0] SUPPORTED_MASK = 64'h4000_0000_0000_0007;
  localparam logic OPT_SAVE_SUPPORTED = 1'h1;
  localparam logic [31:0] SUBFN_SIZES = 32'h0000_0000;
  localparam logic [31:0] SUBFN_FEATURES = 32'h0000_0001;
  localparam int OPT_SAVE_RESULT_BIT = 0;

  // ----------------------------------------------------------------
  // Fixed save-area layout, byte offsets and sizes
  // ----------------------------------------------------------------
  localparam logic [31:0] LEGACY_SIZE = 32'h0000_0200;
  localparam logic [31:0] HEADER_OFS = 32'h0000_0200;
  localparam logic [31:0] HEADER_SIZE = 32'h0000_0040;
  localparam logic [31:0] WIDE_VEC_OFS = 32'h0000_0240;
  localparam logic [31:0] WIDE_VEC_SIZE = 32'h0000_0100;
  localparam logic [31:0] PROFILING_OFS = 32'h0000_0340;
  localparam logic [31:0] PROFILING_SIZE = 32'h0000_0080;
  localparam logic [11:0] SW_AREA_FIRST = 12'h1D0;
  localparam logic [11:0] SW_AREA_LAST = 12'h1FF;

  // ----------------------------------------------------------------
  // State operation kinds
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    XSM_OP_SAVE,
    XSM_OP_SAVE_OPT,
    XSM_OP_RESTORE,
    XSM_OP_NONE
  } xsm_op_t;

endpackage : xsm_pkg

// file: sim/test_xsm_enable_mask.sv
// Self-checking testbench for the extended-state enable mask block.
`timescale 1ns/1ns
`default_nettype none

module test_xsm_enable_mask;
  logic clk = 1'b0, rst = 1'b1, xreg_rd_req = 1'b0, xreg_wr_req = 1'b0, wide_vec_exec = 1'b0;
  logic state_op_req = 1'b0, query_req = 1'b0, xreg_done, protection_fault, undefined_opcode_fault;
  logic profiling_state_enable, wide_vector_usable, state_op_done, upper_vector_write_en;
  logic image_byte_ignored, query_done;
  logic [1:0] priv_ring = 2'h0, state_op_kind = 2'h3;
  logic [11:0] image_byte_offset = 12'h000;
  logic [31:0] control_register_four = 32'h0004_0000, xreg_index = 32'h0, query_subfn = 32'h0;
  logic [31:0] query_result_a, query_result_b, query_result_c, query_result_d;
  logic [63:0] xreg_wr_data = 64'h0, operand_mask_pair = 64'h0, saved_component_vector = 64'h0;
  logic [63:0] xreg_rd_data, feature_state_enable_mask, op_select_mask, op_load_mask, op_init_mask;
  logic [63:0] op_saved_vector_set;
  int error_cnt = 0;
  int checks_done = 0;

  xsm_enable_mask u_xsm_enable_mask (.*);

  // Free-running 100 MHz clock.
  always #5 clk = ~clk;

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  // Inputs move 1 ns after the edge so the sampling edge never races them.
  task automatic step;
    @(posedge clk);
    #1;
  endtask : step

  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // One access; the leading edge keeps back-to-back calls from reassigning a strobe at once.
  task automatic xacc(input logic wr, input logic [31:0] idx, input logic [63:0] data, input logic [2:0] exp);
    step();
    xreg_wr_req = wr;
    xreg_rd_req = !wr;
    xreg_index = idx;
    xreg_wr_data = data;
    step();
    check("answer", {61'h0, xreg_done, protection_fault, undefined_opcode_fault}, {61'h0, exp});
    xreg_wr_req = 1'b0;
    xreg_rd_req = 1'b0;
  endtask : xacc

  task automatic op(input logic [1:0] kind, input logic [63:0] opnd, input logic [63:0] saved);
    step();
    state_op_req = 1'b1;
    state_op_kind = kind;
    operand_mask_pair = opnd;
    saved_component_vector = saved;
    step();
    check("op done", {63'h0, state_op_done}, {63'h0, kind != 2'h3});
    state_op_req = 1'b0;
  endtask : op

  task automatic qry(input logic [31:0] subfn);
    step();
    query_req = 1'b1;
    query_subfn = subfn;
    step();
    check("query done", {63'h0, query_done}, 64'h1);
    query_req = 1'b0;
  endtask : qry

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_gate;
    check("reset mask", feature_state_enable_mask, 64'h1);
    xacc(1'b0, 32'h0, 64'h0, 3'h4);
    check("read data", xreg_rd_data, 64'h1);
    control_register_four = 32'h0;
    xacc(1'b1, 32'h0, 64'h7, 3'h1);
    xacc(1'b0, 32'h0, 64'h0, 3'h1);
    step();
    wide_vec_exec = 1'b1;
    step();
    check("wide fault", {63'h0, undefined_opcode_fault}, 64'h1);
    wide_vec_exec = 1'b0;
    control_register_four = 32'h0004_0000;
    check("mask kept", feature_state_enable_mask, 64'h1);
    $display("test gate done");
  endtask : t_gate

  task automatic t_faults;
    logic [63:0] bad [5] = '{64'h8, 64'h8000_0000_0000_0007, 64'h0, 64'h5, 64'h0000_0001_0000_0003};
    foreach (bad[i]) begin
      xacc(1'b1, 32'h0, bad[i], 3'h2);
      check("mask after refusal", feature_state_enable_mask, 64'h1);
    end
    priv_ring = 2'h3;
    xacc(1'b1, 32'h0, 64'h7, 3'h2);
    xacc(1'b0, 32'h0, 64'h0, 3'h4);
    priv_ring = 2'h0;
    xacc(1'b1, 32'h1, 64'h3, 3'h2);
    $display("test faults done");
  endtask : t_faults

  task automatic t_good;
    qry(32'h0);
    check("supported first", {32'h0, query_result_c}, 64'h7);
    check("size base", {32'h0, query_result_a}, 64'h240);
    xacc(1'b1, 32'h0, 64'h3, 3'h4);
    check("usable off", {63'h0, wide_vector_usable}, 64'h0);
    xacc(1'b1, 32'h0, 64'h7, 3'h4);
    check("usable on", {63'h0, wide_vector_usable}, 64'h1);
    qry(32'h0);
    check("size", {32'h0, query_result_a}, 64'h340);
    check("supported", {32'h0, query_result_c}, 64'h7);
    check("size supported", {32'h0, query_result_b}, 64'h3C0);
    check("supported high", {32'h0, query_result_d}, 64'h4000_0000);
    xacc(1'b1, 32'h0, 64'h4000_0000_0000_0007, 3'h4);
    check("profiling", {63'h0, profiling_state_enable}, 64'h1);
    xacc(1'b0, 32'h0, 64'h0, 3'h4);
    check("read back", xreg_rd_data, 64'h4000_0000_0000_0007);
    qry(32'h0);
    check("size all", {32'h0, query_result_a}, 64'h3C0);
    qry(32'h1);
    check("opt save", {32'h0, query_result_a}, 64'h1);
    $display("test good done");
  endtask : t_good

  task automatic t_ops;
    op(2'h2, 64'hFFFF_FFFF_FFFF_FFFF, 64'h1);
    check("restore saved", op_saved_vector_set, 64'h0);
    check("upper write", {63'h0, upper_vector_write_en}, 64'h1);
    check("select", op_select_mask, 64'h4000_0000_0000_0007);
    check("load", op_load_mask, 64'h1);
    check("init", op_init_mask, 64'h4000_0000_0000_0006);
    op(2'h0, 64'h8000_0000_0000_0005, 64'h0);
    check("save load", op_load_mask, 64'h0);
    check("save upper", {63'h0, upper_vector_write_en}, 64'h0);
    check("saved set", op_saved_vector_set, 64'h5);
    op(2'h1, 64'h4000_0000_0000_0002, 64'h0);
    check("opt select", op_select_mask, 64'h4000_0000_0000_0002);
    op(2'h3, 64'h7, 64'h0);
    $display("test ops done");
  endtask : t_ops

  task automatic t_image;
    logic [11:0] ofs [4] = '{12'h1CF, 12'h1D0, 12'h1FF, 12'h200};
    logic [3:0] exp = 4'h6;
    foreach (ofs[i]) begin
      image_byte_offset = ofs[i];
      step();
      check("ignored", {63'h0, image_byte_ignored}, {63'h0, exp[3 - i]});
    end
    $display("test image done");
  endtask : t_image

  // A reset in mid-run must bring the mask and the data outputs back to their reset values.
  task automatic t_reset;
    step();
    rst = 1'b1;
    step();
    check("mask after reset", feature_state_enable_mask, 64'h1);
    check("read data after reset", xreg_rd_data, 64'h0);
    check("size after reset", {32'h0, query_result_a}, 64'h0);
    check("profiling after reset", {63'h0, profiling_state_enable}, 64'h0);
    rst = 1'b0;
    xacc(1'b0, 32'h0, 64'h0, 3'h4);
    check("read after reset", xreg_rd_data, 64'h1);
    $display("test reset done");
  endtask : t_reset

  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : results

  // Main sequence: ten reset cycles, then every scenario.
  initial begin
    repeat (10) @(posedge clk);
    #1;
    rst = 1'b0;
    t_gate();
    t_faults();
    t_good();
    t_ops();
    t_image();
    t_reset();
    results();
  end

  // The tests need about 70 cycles; a hang is cut after over forty times that.
  initial begin
    #30000;
    error_cnt++;
    results();
  end
endmodule : test_xsm_enable_mask
`default_nettype wire

// file: sim/xsm_enable_mask_chk.sv
// Concurrent checks on the ports of the extended-state enable mask block.
`timescale 1ns/1ns
`default_nettype none

module xsm_enable_mask_chk (
  input wire logic clk, // Core clock.
  input wire logic rst, // Synchronous reset.
  input wire logic [31:0] control_register_four, // OS enable in bit 18.
  input wire logic [1:0] priv_ring, // Privilege ring.
  input wire logic xreg_rd_req, // Read pulse.
  input wire logic xreg_wr_req, // Write pulse.
  input wire logic [31:0] xreg_index, // Register index.
  input wire logic [63:0] xreg_wr_data, // Write value.
  input wire logic xreg_done, // Access success.
  input wire logic protection_fault, // Protection fault.
  input wire logic undefined_opcode_fault, // Undefined-opcode fault.
  input wire logic [63:0] feature_state_enable_mask, // Enable mask.
  input wire logic wide_vector_usable, // Wide vectors usable.
  input wire logic wide_vec_exec, // Wide vector issue.
  input wire logic state_op_req, // State operation pulse.
  input wire logic [1:0] state_op_kind, // Operation kind.
  input wire logic [63:0] operand_mask_pair, // Operand mask.
  input wire logic state_op_done, // Operation answer.
  input wire logic [63:0] op_select_mask, // Selected components.
  input wire logic [11:0] image_byte_offset, // Image byte.
  input wire logic image_byte_ignored // Byte skipped.
);
  // ----------------------------------------------------------------
  // Helper logic
  // ----------------------------------------------------------------
  logic [63:0] sel_exp_q;
  // Decoded conditions; the reserved mask leaves bit 62 legal since profiling is supported.
  wire logic os_en = control_register_four[xsm_pkg::OS_MGMT_ENABLE_BIT];
  wire logic legal_ctx = os_en && priv_ring == xsm_pkg::RING_KERNEL && xreg_index == xsm_pkg::XREG_IDX_MASK;
  wire logic bad_val = |(xreg_wr_data & xsm_pkg::MASK_RSVD) || !xreg_wr_data[0]
    || xreg_wr_data[2:1] == xsm_pkg::BAD_VEC_PAIR;

  // Expected selection, captured at the edge that takes the operation.
  always_ff @(posedge clk) begin
    sel_exp_q <= operand_mask_pair & feature_state_enable_mask;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_reset_value; $fell(rst) |-> feature_state_enable_mask == xsm_pkg::MASK_RESET; endproperty
  a_reset_value: assert property (p_reset_value) else $error("mask not at reset value");
  property p_bad_write; xreg_wr_req && legal_ctx && bad_val |=> protection_fault && !xreg_done; endproperty
  a_bad_write: assert property (p_bad_write) else $error("illegal write value accepted");
  property p_fault_keeps; protection_fault |-> $stable(feature_state_enable_mask); endproperty
  a_fault_keeps: assert property (p_fault_keeps) else $error("mask changed on refused write");
  property p_rsvd_zero; (feature_state_enable_mask & xsm_pkg::MASK_RSVD) == 64'h0; endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved mask bit set");
  property p_fp_always; feature_state_enable_mask[xsm_pkg::BIT_SCALAR_FP]; endproperty
  a_fp_always: assert property (p_fp_always) else $error("scalar bit clear");
  property p_wide_usable; wide_vector_usable == (os_en && feature_state_enable_mask[2:1] == xsm_pkg::WIDE_VEC_PAIR);
  endproperty
  a_wide_usable: assert property (p_wide_usable) else $error("wide vector usable wrong");
  property p_ring_write; xreg_wr_req && os_en && priv_ring != xsm_pkg::RING_KERNEL |=> protection_fault; endproperty
  a_ring_write: assert property (p_ring_write) else $error("write outside kernel ring accepted");
  property p_ring_read; xreg_rd_req && !xreg_wr_req && os_en && xreg_index == 32'h0 |=> xreg_done; endproperty
  a_ring_read: assert property (p_ring_read) else $error("legal read refused");
  property p_os_gate; (xreg_wr_req || xreg_rd_req) && !os_en |=> undefined_opcode_fault && !xreg_done; endproperty
  a_os_gate: assert property (p_os_gate) else $error("access without OS enable");
  property p_op_select; state_op_req && state_op_kind != 2'h3 |=> state_op_done && op_select_mask == sel_exp_q;
  endproperty
  a_op_select: assert property (p_op_select) else $error("state operation selection wrong");
  property p_wide_fault; wide_vec_exec && !wide_vector_usable |=> undefined_opcode_fault; endproperty
  a_wide_fault: assert property (p_wide_fault) else $error("wide vector issue not faulted");
  property p_sw_area; !$past(rst) |-> image_byte_ignored == ($past(image_byte_offset) >= xsm_pkg::SW_AREA_FIRST
    && $past(image_byte_offset) <= xsm_pkg::SW_AREA_LAST); endproperty
  a_sw_area: assert property (p_sw_area) else $error("software area decode wrong");
endmodule : xsm_enable_mask_chk

bind xsm_enable_mask xsm_enable_mask_chk u_xsm_enable_mask_chk (.*);
`default_nettype wire
